// ===== csm_master_tx.sv
// Four-channel clocked serial unit, master transmission, APB register slave.
// Assumes one clock pclk; serial data inputs come from pins, other clocks.
`include "csm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module csm_master_tx (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial pins, one bit per channel
  output logic [3:0]       sck_out,
  output logic [3:0]       sdo_out,
  input  wire logic [3:0]  sdi_in,
  // One-cycle event per channel
  output logic [3:0]       channel_transfer_event
);

  function automatic logic ch_addr(input logic [7:0] a,
                                   input logic [7:0] base,
                                   input int ch);
    ch_addr = (a == base + 8'(ch * 4));
  endfunction : ch_addr

  // Picks the data bit for a half-period position.
  function automatic logic pick_bit(input logic [7:0] w, input logic len8,
                                    input logic lsb, input logic [2:0] idx);
    logic [2:0] top;
    top = len8 ? 3'd7 : 3'd6;
    pick_bit = lsb ? w[idx] : w[top - idx];
  endfunction : pick_bit

  ////////////////////////////////////////////////////////////////////////////
  // APB decode.

  logic [3:0]  out_en_reg, en_reg, stop_reg, sdi_s1_reg, sdi_s2_reg;
  logic [11:0] out_lvl_reg;
  logic [`CSM_CFG_W-1:0] cfg_all  [4];
  logic [7:0]            dat_all  [4];
  logic [3:0]  bff_all, busy_all, sck_all, so_all;
  logic [31:0] rd_mux;
  logic        mapped, ack_reg;

  // One wait state: read data is loaded in the first access cycle, so the
  // flop already holds it at the edge where pready is sampled high.
  wire wr_acc = psel && penable && pwrite && ack_reg;
  wire rd_acc = psel && penable && !pwrite && !ack_reg;
  wire wr_oe  = wr_acc && paddr == `CSM_OFF_OUT_EN;
  wire wr_ss  = wr_acc && paddr == `CSM_OFF_START;
  wire wr_st  = wr_acc && paddr == `CSM_OFF_STOP;
  wire wr_lvl = wr_acc && paddr == `CSM_OFF_OUT_LVL;

  assign pready  = ack_reg;
  assign pslverr = psel && penable && ack_reg && !mapped;

  always_comb begin
    rd_mux = 32'h0;
    mapped = 1'b1;
    case (paddr)
      `CSM_OFF_OUT_EN:  rd_mux = {28'h0, out_en_reg};
      `CSM_OFF_START:   rd_mux = 32'h0;
      `CSM_OFF_STOP:    rd_mux = {28'h0, stop_reg};
      `CSM_OFF_EN_STAT: rd_mux = {28'h0, en_reg};
      `CSM_OFF_OUT_LVL: rd_mux = {20'h0, out_lvl_reg};
      `CSM_OFF_SDI:     rd_mux = {28'h0, sdi_s2_reg};
      default: begin
        mapped = 1'b0;
        for (int i = 0; i < `CSM_NCH; i++) begin
          if (ch_addr(paddr, `CSM_OFF_CFG0, i)) begin
            rd_mux = {{(32 - `CSM_CFG_W){1'b0}}, cfg_all[i]};
            mapped = 1'b1;
          end
          if (ch_addr(paddr, `CSM_OFF_DATA0, i)) begin
            rd_mux = {24'h0, dat_all[i]};
            mapped = 1'b1;
          end
          if (ch_addr(paddr, `CSM_OFF_STAT0, i)) begin
            rd_mux = {30'h0, busy_all[i], bff_all[i]};
            mapped = 1'b1;
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unit-wide registers.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata      <= 32'h0;
      ack_reg     <= 1'b0;
      out_en_reg  <= 4'h0;
      en_reg      <= 4'h0;
      stop_reg    <= 4'h0;
      out_lvl_reg <= `CSM_LVL_RST;
      sdi_s1_reg  <= 4'h0;
      sdi_s2_reg  <= 4'h0;
    end else begin
      prdata     <= rd_acc ? rd_mux : prdata;
      ack_reg    <= psel && penable && !ack_reg;
      sdi_s1_reg <= sdi_in;
      sdi_s2_reg <= sdi_s1_reg;
      if (wr_oe)
        out_en_reg <= pwdata[3:0];
      if (wr_lvl)
        out_lvl_reg <= pwdata[11:0];
      // A start write holds off a stop pending on the same bit for one cycle; the stop then clears it.
      en_reg   <= wr_ss ? (en_reg | pwdata[3:0])
                        : (en_reg & ~stop_reg);
      stop_reg <= (wr_st ? (stop_reg | pwdata[3:0]) : stop_reg)
                  & (wr_st ? 4'hf : en_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel engines.

  for (genvar i = 0; i < `CSM_NCH; i++) begin : g_ch
    logic [`CSM_CFG_W-1:0] cfg_reg, cfg_next;
    logic [7:0]  dat_reg, shf_reg, shf_next;
    logic [14:0] pre_reg, pre_next, pre_lim;
    logic [6:0]  div_reg, div_next, div_lim;
    logic [3:0]  h_reg, h_next, h_last;
    logic [2:0]  idx;
    logic        bff_reg, bff_next, evt_reg, evt_next;
    logic        sck_reg, so_reg, sck_pin_reg, so_pin_reg;
    csm_pkg::csm_state_t st_reg, st_next;

    wire len8  = cfg_reg[`CSM_F_LEN8];
    wire dap   = cfg_reg[`CSM_F_DAP];
    wire cont  = cfg_reg[`CSM_F_CONT];
    wire [3:0] pexp = cfg_reg[`CSM_F_PRE_HI:`CSM_F_PRE_LO];
    wire [6:0] dcfg = cfg_reg[`CSM_F_DIV_HI:`CSM_F_DIV_LO];
    wire mtx   = cfg_reg[`CSM_F_MODE_HI:`CSM_F_MODE_LO]
                 == csm_pkg::CSM_MD_MTX;
    wire wr_cfg = wr_acc && ch_addr(paddr, `CSM_OFF_CFG0, i);
    wire wr_dat = wr_acc && ch_addr(paddr, `CSM_OFF_DATA0, i);
    wire pre_tk = pre_reg == pre_lim;
    wire tick   = pre_tk && div_reg == div_lim;
    wire start  = en_reg[i] && mtx && bff_reg;

    assign pre_lim = 15'((16'h1 << pexp) - 16'h1);
    // Slow channels never get a single-cycle half period.
    assign div_lim = (i != `CSM_FAST_CH && pexp == 4'h0 && dcfg == 7'h0)
                     ? 7'h1 : dcfg;
    assign h_last  = len8 ? 4'd15 : 4'd13;
    assign idx = (st_next != csm_pkg::CSM_ST_SHIFT) ? 3'd0
               : dap ? 3'(((h_next + 4'd1) >> 1) > {1'b0, h_last[3:1]}
                         ? h_last[3:1] : (h_next + 4'd1) >> 1)
               : 3'(h_next >> 1);

    always_comb begin
      cfg_next = wr_cfg ? pwdata[`CSM_CFG_W-1:0] : cfg_reg;
      if (i != 0)
        cfg_next[`CSM_F_WAKE] = 1'b0;
      st_next  = st_reg;
      h_next   = h_reg;
      shf_next = shf_reg;
      evt_next = 1'b0;
      bff_next = bff_reg;
      pre_next = (st_reg == csm_pkg::CSM_ST_IDLE || pre_tk) ? 15'h0
                 : pre_reg + 15'h1;
      div_next = (st_reg == csm_pkg::CSM_ST_IDLE || tick) ? 7'h0
                 : pre_tk ? div_reg + 7'h1 : div_reg;
      case (st_reg)
        csm_pkg::CSM_ST_IDLE: begin
          if (start) begin
            shf_next = dat_reg;
            bff_next = 1'b0;
            h_next   = 4'd0;
            evt_next = cont;
            st_next  = dap ? csm_pkg::CSM_ST_LEAD : csm_pkg::CSM_ST_SHIFT;
          end
        end
        csm_pkg::CSM_ST_LEAD: begin
          if (tick)
            st_next = csm_pkg::CSM_ST_SHIFT;
        end
        csm_pkg::CSM_ST_SHIFT: begin
          if (tick) begin
            if (h_reg == h_last) begin
              st_next  = csm_pkg::CSM_ST_IDLE;
              evt_next = !cont;
            end else begin
              h_next = h_reg + 4'd1;
            end
          end
        end
        default: st_next = csm_pkg::CSM_ST_IDLE;
      endcase
      if (!en_reg[i])
        st_next = csm_pkg::CSM_ST_IDLE;
      if (wr_dat)
        bff_next = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cfg_reg <= `CSM_CFG_RST;
        dat_reg <= 8'h0;
        shf_reg <= 8'h0;
        pre_reg <= 15'h0;
        div_reg <= 7'h0;
        h_reg   <= 4'd0;
        bff_reg <= 1'b0;
        evt_reg <= 1'b0;
        sck_reg <= 1'b1;
        so_reg  <= 1'b1;
        st_reg  <= csm_pkg::CSM_ST_IDLE;
      end else begin
        cfg_reg <= cfg_next;
        dat_reg <= wr_dat ? pwdata[7:0] : dat_reg;
        shf_reg <= shf_next;
        pre_reg <= pre_next;
        div_reg <= div_next;
        h_reg   <= h_next;
        bff_reg <= bff_next;
        evt_reg <= evt_next;
        st_reg  <= st_next;
        sck_reg <= (st_next == csm_pkg::CSM_ST_SHIFT) ? h_next[0] : 1'b1;
        so_reg  <= (st_next == csm_pkg::CSM_ST_IDLE) ? so_reg
                   : pick_bit(shf_next, len8, cfg_reg[`CSM_F_LSB], idx);
      end
    end

    // Pins are retimed once so every pin change lands on one clock edge.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sck_pin_reg <= 1'b1;
        so_pin_reg  <= 1'b1;
      end else begin
        sck_pin_reg <= en_reg[i] ? sck_reg ^ cfg_reg[`CSM_F_CKP]
                                 : out_lvl_reg[8 + i];
        so_pin_reg  <= out_en_reg[i] ? so_reg : out_lvl_reg[i];
      end
    end

    assign cfg_all[i] = cfg_reg;
    assign dat_all[i] = dat_reg;
    assign bff_all[i] = bff_reg;
    assign busy_all[i] = st_reg != csm_pkg::CSM_ST_IDLE;
    assign sck_all[i] = sck_pin_reg;
    assign so_all[i]  = so_pin_reg;
    assign channel_transfer_event[i] = evt_reg;
  end

  assign sck_out = sck_all;
  assign sdo_out = so_all;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on channels 0 and 1.

  wire c0_idle  = g_ch[0].st_reg == csm_pkg::CSM_ST_IDLE;
  wire c0_shift = g_ch[0].st_reg == csm_pkg::CSM_ST_SHIFT;
  wire c0_wrd   = wr_acc && paddr == `CSM_OFF_DATA0;

  sequence s_load0;
    c0_idle && g_ch[0].start;
  endsequence
  sequence s_end0;
    c0_shift && g_ch[0].tick && g_ch[0].h_reg == g_ch[0].h_last;
  endsequence

  property p_stop_clears;
    @(posedge pclk) disable iff (!presetn)
      (!wr_st && !wr_ss && stop_reg[0]) |=> !en_reg[0] ##1 !stop_reg[0];
  endproperty
  a_stop_clears: assert property (p_stop_clears)
    else $error("stop trigger did not clear after disable");

  property p_start_sets;
    @(posedge pclk) disable iff (!presetn)
      (wr_ss && pwdata[0]) |=> en_reg[0];
  endproperty
  a_start_sets: assert property (p_start_sets)
    else $error("start bit did not enable channel");

  property p_write_full;
    @(posedge pclk) disable iff (!presetn)
      c0_wrd |=> g_ch[0].bff_reg && g_ch[0].dat_reg == $past(pwdata[7:0]);
  endproperty
  a_write_full: assert property (p_write_full)
    else $error("data write lost or buffer flag not set");

  property p_idle_clock;
    @(posedge pclk) disable iff (!presetn)
      (c0_idle && en_reg[0]) |=> ##1
        sck_out[0] == $past(g_ch[0].cfg_reg[`CSM_F_CKP]) ^ $past(c0_idle, 2)
        || !$past(en_reg[0]) || !$past(c0_idle);
  endproperty
  a_idle_clock: assert property (p_idle_clock)
    else $error("serial clock not at idle level");

  property p_end_event;
    @(posedge pclk) disable iff (!presetn)
      (s_end0 ##0 (en_reg[0] && !g_ch[0].cont))
        |=> c0_idle || g_ch[0].start ##0 channel_transfer_event[0];
  endproperty
  a_end_event: assert property (p_end_event)
    else $error("transfer end event missing");

  property p_load_empty;
    @(posedge pclk) disable iff (!presetn)
      (s_load0 ##0 g_ch[0].cont && !c0_wrd)
        |=> channel_transfer_event[0] && !g_ch[0].bff_reg;
  endproperty
  a_load_empty: assert property (p_load_empty)
    else $error("buffer empty event missing at load");

  property p_lead;
    @(posedge pclk) disable iff (!presetn)
      (s_load0 ##0 g_ch[0].dap) |=> g_ch[0].st_reg == csm_pkg::CSM_ST_LEAD;
  endproperty
  a_lead: assert property (p_lead)
    else $error("data phase lead state skipped");

  property p_oe_off;
    @(posedge pclk) disable iff (!presetn)
      (!out_en_reg[0] && !wr_lvl) |=> sdo_out[0] == out_lvl_reg[0];
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("disabled output not held at level register");

  property p_slow_half;
    @(posedge pclk) disable iff (!presetn)
      (g_ch[1].tick && g_ch[1].st_reg != csm_pkg::CSM_ST_IDLE)
        |=> !g_ch[1].tick;
  endproperty
  a_slow_half: assert property (p_slow_half)
    else $error("channel 1 half period shorter than two cycles");

  property p_len;
    @(posedge pclk) disable iff (!presetn)
      (c0_shift && g_ch[0].tick && en_reg[0])
        |-> g_ch[0].h_reg <= (g_ch[0].len8 ? 4'd15 : 4'd13);
  endproperty
  a_len: assert property (p_len)
    else $error("half-period count beyond word length");

endmodule : csm_master_tx
`default_nettype wire

// ===== csm_cfg.svh
// Offsets, field positions, reset values and limits of the serial channel.
// Assumes nothing; included by the top module.
`ifndef CSM_CFG_SVH
`define CSM_CFG_SVH
`define CSM_NCH          4
`define CSM_OFF_OUT_EN   8'h00
`define CSM_OFF_START    8'h04
`define CSM_OFF_STOP     8'h08
`define CSM_OFF_EN_STAT  8'h0c
`define CSM_OFF_OUT_LVL  8'h10
`define CSM_OFF_SDI      8'h14
`define CSM_OFF_CFG0     8'h20
`define CSM_OFF_DATA0    8'h40
`define CSM_OFF_STAT0    8'h60
`define CSM_F_LEN8       0
`define CSM_F_LSB        1
`define CSM_F_DAP        2
`define CSM_F_CKP        3
`define CSM_F_CONT       4
`define CSM_F_MODE_LO    5
`define CSM_F_MODE_HI    7
`define CSM_F_WAKE       8
`define CSM_F_PRE_LO     9
`define CSM_F_PRE_HI     12
`define CSM_F_DIV_LO     13
`define CSM_F_DIV_HI     19
`define CSM_CFG_W        20
`define CSM_CFG_RST      20'h00001
`define CSM_LVL_RST      12'hf0f
`define CSM_FAST_CH      0
`endif

// ===== csm_pkg.sv
// Types shared by the serial channel design.
// Assumes nothing; uses nothing from csm_cfg.svh.
`default_nettype none
package csm_pkg;
  typedef enum logic [1:0] {
    CSM_ST_IDLE  = 2'b00,
    CSM_ST_LEAD  = 2'b01,
    CSM_ST_SHIFT = 2'b10
  } csm_state_t;
  typedef enum logic [2:0] {
    CSM_MD_MTX   = 3'b000,
    CSM_MD_MRX   = 3'b001,
    CSM_MD_MTRX  = 3'b010,
    CSM_MD_STX   = 3'b011,
    CSM_MD_SRX   = 3'b100,
    CSM_MD_STRX  = 3'b101,
    CSM_MD_WAKE  = 3'b110
  } csm_mode_t;
endpackage : csm_pkg
`default_nettype wire

// ===== csm_slave_model.sv
// Model of the external slave that receives one channel's serial words.
// Assumes the bench routes the watched channel's pins to it.
`timescale 1ns/1ps
`default_nettype none
module csm_slave_model (
  // Clock
  input  wire logic        pclk,
  // Serial pins of the watched channel
  input  wire logic        sck,
  input  wire logic        sdo,
  output logic             sdi,
  // Capture control and result
  input  wire logic        sample_fall,
  input  wire logic        clr,
  output logic [31:0]      rx_bits,
  output logic [7:0]       rx_count
);
  logic sck_q;
  // The return line toggles every cycle, so a stale level is never
  // mistaken for data.
  initial sdi = 1'b0;
  always @(posedge pclk) sdi <= ~sdi;
  always @(posedge pclk) begin
    sck_q <= sck;
    if (clr) begin
      rx_bits  <= 32'h0;
      rx_count <= 8'h0;
    end else if (sck !== sck_q && sck === ~sample_fall) begin
      rx_bits  <= {rx_bits[30:0], sdo};
      rx_count <= rx_count + 8'h1;
    end
  end
endmodule : csm_slave_model
`default_nettype wire

// ===== tb_csm_master_tx.sv
// Self-checking bench for the serial channel unit.
// Assumes the APB slave may insert wait states; read data stands with pready.
`timescale 1ns/1ps
`default_nettype none
module tb_csm_master_tx;
  logic        pclk, presetn, psel, penable, pwrite, clr, samp_fall;
  logic        pready, pslverr, err, sdi;
  logic [7:0]  paddr, rx_count;
  logic [31:0] pwdata, prdata, rx_bits, rd, seed;
  logic [3:0]  sck_out, sdo_out, ev;
  logic [7:0]  w [3];
  int          miscompares, num_checks, ev_cnt, exp_ev, ch, n, len;

  csm_master_tx i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sck_out(sck_out), .sdo_out(sdo_out), .sdi_in({4{sdi}}),
    .channel_transfer_event(ev));
  csm_slave_model i_slave (.pclk(pclk), .sck(sck_out[ch]),
    .sdo(sdo_out[ch]), .sdi(sdi), .sample_fall(samp_fall), .clr(clr),
    .rx_bits(rx_bits), .rx_count(rx_count));

  ////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) if (ev[ch] === 1'b1) ev_cnt <= ev_cnt + 1;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Bits in the order they leave the pin, first bit in the highest place.
  function automatic logic [7:0] order(input logic [7:0] d, input int l,
                                       input logic lsb);
    logic [7:0] r;
    r = 8'h0;
    for (int j = 0; j < l; j++) r = {r[6:0], lsb ? d[j] : d[l-1-j]};
    return r;
  endfunction : order
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  // Read data and error are taken at the edge where pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int k;
    k = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) miscompares++;
    err = pslverr;
    rd  = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic chk(input logic [7:0] a, input logic [31:0] e,
                     input string m);
    apb(1'b0, a, 32'h0);
    check(rd, e, m);
  endtask : chk
  // A config change may move the idle clock level, so capture restarts.
  task automatic setup(input int c, input logic [19:0] cfg);
    ch = c;
    apb(1'b1, 8'h20 + 8'(4 * c), {12'h0, cfg});
    samp_fall <= cfg[2] ^ cfg[3];
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
  endtask : setup
  task automatic wait_ev();
    n = 0;
    while (ev_cnt < exp_ev && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) miscompares++;
    repeat (4) @(posedge pclk);
  endtask : wait_ev

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    $display("FAIL t=%0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    {psel, penable, pwrite, samp_fall, presetn} = 5'h0;
    paddr  = 8'h0;
    pwdata = 32'h0;
    clr    = 1'b1;
    ch     = 1;
    seed   = 32'he85f3faa;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(8'h10, 32'hf0f, "level reset");
    chk(8'h20, 32'h1, "config reset");
    chk(8'h0c, 32'h0, "enable reset");
    apb(1'b0, 8'h7c, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped address");
    apb(1'b1, 8'h10, 32'hf0b);
    repeat (2) @(posedge pclk);
    check({31'h0, sdo_out[2]}, 32'h0, "disabled data pin");
    apb(1'b1, 8'h00, 32'h3);
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b1, 8'h04, 32'h2);
    chk(8'h0c, 32'h3, "enable status");
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      setup((i[1] ^ i[2]) ? 1 : 0, 20'(i));
      apb(1'b1, 8'h40 + 8'(4 * ch), {24'h0, seed[7:0]});
      exp_ev++;
      wait_ev();
      len = i[0] ? 8 : 7;
      check(32'(ev_cnt), 32'(exp_ev), "single event");
      check({24'h0, rx_count}, 32'(len), "bit count");
      check(rx_bits, {24'h0, order(seed[7:0], len, i[1])}, "word");
    end
    setup(1, 20'h00011);
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      w[k] = seed[7:0];
      apb(1'b1, 8'h44, {24'h0, w[k]});
    end
    exp_ev += 2;
    wait_ev();
    n = 0;
    do begin
      apb(1'b0, 8'h64, 32'h0);
      n++;
    end while (rd[1] !== 1'b0 && n < 100);
    if (n >= 100) miscompares++;
    repeat (4) @(posedge pclk);
    check(32'(ev_cnt), 32'(exp_ev), "empty events");
    check({24'h0, rx_count}, 32'd16, "stream bits");
    check(rx_bits, {16'h0, order(w[0], 8, 1'b0), order(w[2], 8, 1'b0)},
          "overwrite");
    setup(1, 20'h00001);
    apb(1'b1, 8'h44, 32'h5a);
    repeat (8) @(posedge pclk);
    apb(1'b1, 8'h08, 32'h2);
    chk(8'h0c, 32'h1, "stop status");
    chk(8'h08, 32'h0, "stop self clear");
    repeat (40) @(posedge pclk);
    check(32'(ev_cnt), 32'(exp_ev), "no event after stop");
    check({31'h0, sck_out[1]}, 32'h1, "stopped clock level");
    finish_test();
  end
endmodule : tb_csm_master_tx
`default_nettype wire
